// [cba_defs.svh]
`ifndef CBA_DEFS_SVH
`define CBA_DEFS_SVH
`define CBA_VEC_PAGE 8'hff
`define CBA_ZERO_PAGE 8'h00
`define CBA_STEP 16'h0001
`define CBA_PC_RST 16'h0000
`define CBA_SP_RST 16'h00ff
`define CBA_HX_RST 16'h0000
`define CBA_BYTE_RST 8'h00
`define CBA_OFS_LO 7:0
`define CBA_SIGN_BIT 7
`endif

// [cba_pkg.sv]
package cba_pkg;
  typedef enum logic [2:0] {
    kind_free,
    kind_fetch,
    kind_read,
    kind_write,
    kind_push,
    kind_pop,
    kind_vector
  } cba_kind_t;

  typedef enum logic [3:0] {
    md_direct,
    md_extended,
    md_indexed,
    md_indexed_offset8,
    md_indexed_offset16,
    md_indexed_post_increment,
    md_indexed_offset8_post_increment,
    md_stack_offset8,
    md_stack_offset16,
    md_relative
  } cba_mode_t;

  typedef enum logic [1:0] {
    st_run,
    st_vec_lo,
    st_vec_hi_data,
    st_vec_lo_data
  } cba_state_t;

  function automatic logic [15:0] add16(input logic [15:0] a, input logic [15:0] b);
    add16 = a + b;
  endfunction
endpackage

// [cba_agen_if.sv]
`timescale 1ns/1ps
interface cba_agen_if;
  cba_pkg::cba_mode_t mode;
  logic [15:0]        hx;
  logic [15:0]        sp;
  logic [15:0]        pc;
  logic [15:0]        offset;
  logic [15:0]        ea;
  logic               post_inc;
  modport gen (input mode, input hx, input sp, input pc, input offset, output ea, output post_inc);
  modport user (output mode, output hx, output sp, output pc, output offset, input ea, input post_inc);
endinterface

// [cba_addr_gen.sv]
`timescale 1ns/1ps
`include "cba_defs.svh"
module cba_addr_gen (
  cba_agen_if.gen ag
);
  logic [15:0] ofs8;
  logic [15:0] rel8;
  logic [15:0] ea_dir;
  logic [15:0] ea_ix_ofs8;
  logic [15:0] ea_ix_ofs16;
  logic [15:0] ea_sp_ofs8;
  logic [15:0] ea_sp_ofs16;
  logic [15:0] ea_rel;

  // Offset byte is unsigned for indexed and stack forms, signed for branches
  assign ofs8        = {8'h00, ag.offset[`CBA_OFS_LO]};
  assign rel8        = {{8{ag.offset[`CBA_SIGN_BIT]}}, ag.offset[`CBA_OFS_LO]};
  assign ea_dir      = {`CBA_ZERO_PAGE, ag.offset[`CBA_OFS_LO]};
  assign ea_ix_ofs8  = cba_pkg::add16(ag.hx, ofs8);
  assign ea_ix_ofs16 = cba_pkg::add16(ag.hx, ag.offset);
  assign ea_sp_ofs8  = cba_pkg::add16(ag.sp, ofs8);
  assign ea_sp_ofs16 = cba_pkg::add16(ag.sp, ag.offset);
  assign ea_rel      = cba_pkg::add16(ag.pc, rel8);

  assign ag.ea =
    (ag.mode == cba_pkg::md_direct)                         ? ea_dir :
    (ag.mode == cba_pkg::md_extended)                       ? ag.offset :
    (ag.mode == cba_pkg::md_indexed)                        ? ag.hx :
    (ag.mode == cba_pkg::md_indexed_post_increment)         ? ag.hx :
    (ag.mode == cba_pkg::md_indexed_offset8)                ? ea_ix_ofs8 :
    (ag.mode == cba_pkg::md_indexed_offset8_post_increment) ? ea_ix_ofs8 :
    (ag.mode == cba_pkg::md_indexed_offset16)               ? ea_ix_ofs16 :
    (ag.mode == cba_pkg::md_stack_offset8)                  ? ea_sp_ofs8 :
    (ag.mode == cba_pkg::md_stack_offset16)                 ? ea_sp_ofs16 :
    (ag.mode == cba_pkg::md_relative)                       ? ea_rel : ag.offset;

  assign ag.post_inc = (ag.mode == cba_pkg::md_indexed_post_increment) ||
                       (ag.mode == cba_pkg::md_indexed_offset8_post_increment);
endmodule

// [cba_bus_cycle.sv]
`timescale 1ns/1ps
`include "cba_defs.svh"
// Functional notes
// - Free cycle lasts one clock, leaves the bus idle, shows as a read.
// - Program fetch reads the byte at the program counter, then advances it.
// - Operand read takes exactly one byte from the effective address.
// - Operand write drives exactly one byte to the effective address.
// - Stack push writes one byte at the stack pointer.
// - Stack pop reads one byte from the stack.
// - Vector fetch reads two bytes from the top page, high byte first.
// - Indexed post-increment: index pair is the address, then index increments.
// - Offset post-increment: index plus unsigned byte offset, then index increments.
// - Indexed forms with no, one-byte or two-byte offset added to index pair.
// - Stack-relative forms add 8-bit or 16-bit offset to stack pointer.
// - Relative form adds a signed offset byte to the program counter.
// - Push stores at stack pointer, then decrements it by one.
module cba_bus_cycle (
  input  wire logic               i_clk_sys,
  input  wire logic               i_arst_n,
  input  wire logic               i_cyc_valid,
  input  wire cba_pkg::cba_kind_t i_cyc_kind,
  input  wire cba_pkg::cba_mode_t i_mode,
  input  wire logic [15:0]        i_offset,
  input  wire logic [7:0]         i_vec_lo,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_take_branch,
  input  wire logic               i_load_hx,
  input  wire logic               i_load_sp,
  input  wire logic [15:0]        i_load_value,
  input  wire logic [7:0]         i_mem_rdata,
  output logic                    o_ready,
  output logic                    o_bus_en,
  output logic                    o_bus_rw,
  output logic [15:0]             o_addr,
  output logic [7:0]              o_wdata,
  output cba_pkg::cba_kind_t      o_cyc_kind,
  output logic [7:0]              o_rdata,
  output logic                    o_rdata_valid,
  output logic [15:0]             o_pc,
  output logic [15:0]             o_sp,
  output logic [15:0]             o_hx
);
  cba_agen_if ag ();
  cba_addr_gen u_agen (.ag(ag));

  cba_pkg::cba_state_t state;
  cba_pkg::cba_state_t next_state;
  logic [7:0]          vec_lo;
  logic [7:0]          vec_hi;
  logic                rd_pending;

  logic                taken;
  logic                is_free;
  logic                is_fetch;
  logic                is_read;
  logic                is_write;
  logic                is_push;
  logic                is_pop;
  logic                is_vec;
  logic [15:0]         sp_inc;
  logic [15:0]         sp_dec;
  logic [15:0]         vec_lo_step;
  logic [15:0]         next_addr;
  logic                next_bus_en;
  logic                next_bus_rw;
  cba_pkg::cba_kind_t  next_kind;
  logic [15:0]         next_pc;
  logic [15:0]         next_sp;
  logic [15:0]         next_hx;
  logic                next_ready;

  assign ag.mode   = i_mode;
  assign ag.hx     = o_hx;
  assign ag.sp     = o_sp;
  assign ag.pc     = o_pc;
  assign ag.offset = i_offset;

  // Requests are only taken between vector sequences
  assign taken    = i_cyc_valid && o_ready && (state == cba_pkg::st_run);
  assign is_free  = taken && (i_cyc_kind == cba_pkg::kind_free);
  assign is_fetch = taken && (i_cyc_kind == cba_pkg::kind_fetch);
  assign is_read  = taken && (i_cyc_kind == cba_pkg::kind_read);
  assign is_write = taken && (i_cyc_kind == cba_pkg::kind_write);
  assign is_push  = taken && (i_cyc_kind == cba_pkg::kind_push);
  assign is_pop   = taken && (i_cyc_kind == cba_pkg::kind_pop);
  assign is_vec   = taken && (i_cyc_kind == cba_pkg::kind_vector);
  assign sp_inc   = cba_pkg::add16(o_sp, `CBA_STEP);
  assign sp_dec   = o_sp - `CBA_STEP;
  // Second vector byte stays in the top page even when the low byte wraps
  assign vec_lo_step = cba_pkg::add16({`CBA_ZERO_PAGE, vec_lo}, `CBA_STEP);

  // One address per clock; unlisted kinds fall to an idle read
  assign next_addr =
    (state == cba_pkg::st_vec_lo) ? {`CBA_VEC_PAGE, vec_lo_step[7:0]} :
    is_vec                        ? {`CBA_VEC_PAGE, i_vec_lo} :
    is_fetch                      ? o_pc :
    (is_read || is_write)         ? ag.ea :
    is_push                       ? o_sp :
    is_pop                        ? sp_inc :
    o_addr;
  assign next_bus_en = is_fetch || is_read || is_write || is_push || is_pop || is_vec ||
                       (state == cba_pkg::st_vec_lo);
  assign next_bus_rw = !(is_write || is_push);
  assign next_kind   = (state == cba_pkg::st_vec_lo) ? cba_pkg::kind_vector :
                       taken ? i_cyc_kind : cba_pkg::kind_free;

  assign next_pc =
    (state == cba_pkg::st_vec_lo_data) ? {vec_hi, i_mem_rdata} :
    is_fetch                           ? cba_pkg::add16(o_pc, `CBA_STEP) :
    (is_free && i_take_branch && (i_mode == cba_pkg::md_relative)) ? ag.ea :
    o_pc;
  assign next_sp =
    i_load_sp ? i_load_value :
    is_push   ? sp_dec :
    is_pop    ? sp_inc :
    o_sp;
  // A load from the sequencer wins over a post-increment in the same clock
  assign next_hx =
    i_load_hx ? i_load_value :
    ((is_read || is_write) && ag.post_inc) ? cba_pkg::add16(o_hx, `CBA_STEP) :
    o_hx;
  assign next_ready = (next_state == cba_pkg::st_run) && !is_vec;

  always_comb begin
    case (state)
      cba_pkg::st_run:         next_state = is_vec ? cba_pkg::st_vec_lo : cba_pkg::st_run;
      cba_pkg::st_vec_lo:      next_state = cba_pkg::st_vec_hi_data;
      cba_pkg::st_vec_hi_data: next_state = cba_pkg::st_vec_lo_data;
      cba_pkg::st_vec_lo_data: next_state = cba_pkg::st_run;
      default:                 next_state = cba_pkg::st_run;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state   <= cba_pkg::st_run;
      o_ready <= 1'b0;
    end else begin
      state   <= next_state;
      o_ready <= next_ready;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_addr     <= {`CBA_ZERO_PAGE, `CBA_ZERO_PAGE};
      o_bus_en   <= 1'b0;
      o_bus_rw   <= 1'b1;
      o_wdata    <= `CBA_BYTE_RST;
      o_cyc_kind <= cba_pkg::kind_free;
    end else begin
      o_addr     <= next_addr;
      o_bus_en   <= next_bus_en;
      o_bus_rw   <= next_bus_rw;
      o_wdata    <= (is_write || is_push) ? i_wdata : o_wdata;
      o_cyc_kind <= next_kind;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pc <= `CBA_PC_RST;
      o_sp <= `CBA_SP_RST;
      o_hx <= `CBA_HX_RST;
    end else begin
      o_pc <= next_pc;
      o_sp <= next_sp;
      o_hx <= next_hx;
    end
  end

  // Memory answers one clock after the address cycle
  always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_pending    <= 1'b0;
      o_rdata       <= `CBA_BYTE_RST;
      o_rdata_valid <= 1'b0;
      vec_lo        <= `CBA_BYTE_RST;
      vec_hi        <= `CBA_BYTE_RST;
    end else begin
      rd_pending    <= o_bus_en && o_bus_rw;
      o_rdata       <= rd_pending ? i_mem_rdata : o_rdata;
      o_rdata_valid <= rd_pending;
      vec_lo        <= is_vec ? i_vec_lo : vec_lo;
      vec_hi        <= (state == cba_pkg::st_vec_hi_data) ? i_mem_rdata : vec_hi;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);

  property p_free_idle;
    is_free |=> (!o_bus_en && o_bus_rw && o_ready);
  endproperty
  a_free_idle: assert property (p_free_idle) else $error("free cycle used the bus");

  property p_fetch_seq;
    is_fetch |=> (o_addr == $past(o_pc)) && (o_pc == $past(o_pc) + 16'h0001) && o_bus_rw;
  endproperty
  a_fetch_seq: assert property (p_fetch_seq) else $error("fetch address or pc step wrong");

  property p_read_ea;
    is_read |=> o_bus_en && o_bus_rw && (o_addr == $past(ag.ea))
            ##2 o_rdata_valid && (o_rdata == $past(i_mem_rdata));
  endproperty
  a_read_ea: assert property (p_read_ea) else $error("operand read not one byte at ea");

  property p_write_ea;
    is_write |=> o_bus_en && !o_bus_rw && (o_addr == $past(ag.ea)) && (o_wdata == $past(i_wdata));
  endproperty
  a_write_ea: assert property (p_write_ea) else $error("operand write wrong");

  property p_push;
    (is_push && !i_load_sp) |=> !o_bus_rw && (o_addr == $past(o_sp)) && (o_sp == $past(o_sp) - 16'h0001);
  endproperty
  a_push: assert property (p_push) else $error("push address or sp step wrong");

  property p_pop;
    (is_pop && !i_load_sp) |=> o_bus_rw && o_bus_en && (o_addr == o_sp) && (o_sp == $past(o_sp) + 16'h0001);
  endproperty
  a_pop: assert property (p_pop) else $error("pop address or sp step wrong");

  property p_vector;
    is_vec |=> (o_addr == {`CBA_VEC_PAGE, $past(i_vec_lo)}) && !o_ready
           ##1 (o_addr == {`CBA_VEC_PAGE, $past(i_vec_lo, 2) + 8'h01}) && o_bus_rw
           ##1 !o_bus_en ##1 o_ready && (o_pc == {$past(o_rdata), o_rdata});
  endproperty
  a_vector: assert property (p_vector) else $error("vector read order wrong");

  property p_post_inc;
    ((is_read || is_write) && ag.post_inc && !i_load_hx) |=> (o_hx == $past(o_hx) + 16'h0001);
  endproperty
  a_post_inc: assert property (p_post_inc) else $error("index not incremented");

  property p_offset8_ea;
    (i_mode == cba_pkg::md_indexed_offset8_post_increment) |-> (ag.ea == o_hx + {8'h00, i_offset[7:0]});
  endproperty
  a_offset8_ea: assert property (p_offset8_ea) else $error("offset post-increment ea wrong");

  property p_stack_ea;
    (i_mode == cba_pkg::md_stack_offset16) |-> (ag.ea == o_sp + i_offset);
  endproperty
  a_stack_ea: assert property (p_stack_ea) else $error("stack offset ea wrong");

  property p_branch;
    (is_free && i_take_branch && (i_mode == cba_pkg::md_relative))
      |=> (o_pc == $past(o_pc) + {{8{$past(i_offset[7])}}, $past(i_offset[7:0])});
  endproperty
  a_branch: assert property (p_branch) else $error("branch target wrong");

  property p_one_kind;
    o_bus_en |-> (o_bus_rw != (o_cyc_kind inside {cba_pkg::kind_write, cba_pkg::kind_push}));
  endproperty
  a_one_kind: assert property (p_one_kind) else $error("cycle direction mismatches kind");

  property p_idle_rw;
    !o_bus_en |-> o_bus_rw;
  endproperty
  a_idle_rw: assert property (p_idle_rw) else $error("idle cycle not shown as read");

  property p_fetch_kind;
    is_fetch |=> o_bus_en && (o_cyc_kind == cba_pkg::kind_fetch);
  endproperty
  a_fetch_kind: assert property (p_fetch_kind) else $error("fetch cycle kind wrong");

  property p_write_kind;
    is_write |=> o_bus_en && (o_cyc_kind == cba_pkg::kind_write);
  endproperty
  a_write_kind: assert property (p_write_kind) else $error("write cycle kind wrong");

  property p_push_data;
    is_push |=> o_bus_en && (o_wdata == $past(i_wdata)) && (o_cyc_kind == cba_pkg::kind_push);
  endproperty
  a_push_data: assert property (p_push_data) else $error("push byte or kind wrong");

  property p_pop_data;
    is_pop |=> ##2 o_rdata_valid && (o_rdata == $past(i_mem_rdata));
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("pop byte not returned");

  property p_vec_busy;
    (state == cba_pkg::st_vec_lo) |-> !o_ready && o_bus_en && (o_cyc_kind == cba_pkg::kind_vector);
  endproperty
  a_vec_busy: assert property (p_vec_busy) else $error("vector cycle not shown on bus");

  property p_hx_ea;
    (i_mode == cba_pkg::md_indexed_post_increment) |-> (ag.ea == o_hx);
  endproperty
  a_hx_ea: assert property (p_hx_ea) else $error("post-increment ea wrong");

  property p_ix8_ea;
    (i_mode == cba_pkg::md_indexed_offset8) |-> (ag.ea == o_hx + {`CBA_ZERO_PAGE, i_offset[7:0]});
  endproperty
  a_ix8_ea: assert property (p_ix8_ea) else $error("indexed byte offset ea wrong");

  property p_ix16_ea;
    (i_mode == cba_pkg::md_indexed_offset16) |-> (ag.ea == o_hx + i_offset);
  endproperty
  a_ix16_ea: assert property (p_ix16_ea) else $error("indexed word offset ea wrong");

  property p_sp8_ea;
    (i_mode == cba_pkg::md_stack_offset8) |-> (ag.ea == o_sp + {`CBA_ZERO_PAGE, i_offset[7:0]});
  endproperty
  a_sp8_ea: assert property (p_sp8_ea) else $error("stack byte offset ea wrong");
endmodule

// [cba_mem_model.sv]
`timescale 1ns/1ps
module cba_mem_model (
  input  wire logic        i_clk_sys,
  input  wire logic        i_bus_en,
  input  wire logic        i_bus_rw,
  input  wire logic [15:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  output logic [7:0]       o_rdata
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int a = 0; a < 65536; a++) begin
      mem[a] = a[7:0] ^ a[15:8] ^ 8'h5a;
    end
    o_rdata = 8'h00;
  end
  // Data answers one cycle after the address; off-read cycles flip so stale bytes never look valid
  always @(posedge i_clk_sys) begin
    if (i_bus_en && i_bus_rw) begin
      o_rdata <= mem[i_addr];
    end else begin
      o_rdata <= ~o_rdata;
    end
    if (i_bus_en && !i_bus_rw) begin
      mem[i_addr] <= i_wdata;
    end
  end
endmodule

// [test_cpu_bus_cycle_addressing.sv]
`timescale 1ns/1ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin num_errors++; $display("[FAIL] %0t %s", $time, m); end end
module test_cpu_bus_cycle_addressing;
  typedef struct {
    cba_pkg::cba_kind_t k;
    cba_pkg::cba_mode_t m;
    logic [15:0]        ofs;
    logic [7:0]         wd;
    logic               br;
    logic [15:0]        addr;
    logic               rw;
    logic               en;
    logic [15:0]        hx;
    logic [15:0]        sp;
    logic [15:0]        pc;
    logic [7:0]         rd;
  } cba_row_t;
  logic               clk = 1'b0, rst_n = 1'b0, valid = 1'b0, br = 1'b0, ld_hx = 1'b0, ld_sp = 1'b0;
  cba_pkg::cba_kind_t kind = cba_pkg::kind_free;
  cba_pkg::cba_mode_t mode = cba_pkg::md_direct;
  logic [15:0]        offset = 16'h0000, ld_val = 16'h0000;
  logic [7:0]         vec_lo = 8'h00, wdata = 8'h00, mem_rd;
  logic               ready, bus_en, bus_rw, rd_valid;
  logic [15:0]        addr, pc, sp, hx;
  logic [7:0]         bus_wd, rdata;
  cba_pkg::cba_kind_t cyc_kind;
  int                 num_errors = 0, n_tests = 0;
  cba_row_t           rows [17] = '{
    '{cba_pkg::kind_fetch, cba_pkg::md_direct, 16'h0000, 8'h00, 0, 16'h0000, 1, 1, 16'h1230, 16'h0200, 16'h0001, 8'h00},
    '{cba_pkg::kind_fetch, cba_pkg::md_direct, 16'h0000, 8'h00, 0, 16'h0001, 1, 1, 16'h1230, 16'h0200, 16'h0002, 8'h00},
    '{cba_pkg::kind_free, cba_pkg::md_direct, 16'h0000, 8'h00, 0, 16'h0001, 1, 0, 16'h1230, 16'h0200, 16'h0002, 8'h00},
    '{cba_pkg::kind_read, cba_pkg::md_direct, 16'h0034, 8'h00, 0, 16'h0034, 1, 1, 16'h1230, 16'h0200, 16'h0002, 8'h6e},
    '{cba_pkg::kind_read, cba_pkg::md_extended, 16'h4567, 8'h00, 0, 16'h4567, 1, 1, 16'h1230, 16'h0200, 16'h0002, 8'h78},
    '{cba_pkg::kind_read, cba_pkg::md_indexed, 16'h0000, 8'h00, 0, 16'h1230, 1, 1, 16'h1230, 16'h0200, 16'h0002, 8'h78},
    '{cba_pkg::kind_read, cba_pkg::md_indexed_offset8, 16'h00f0, 8'h00, 0, 16'h1320, 1, 1, 16'h1230, 16'h0200, 16'h0002,
      8'h69},
    '{cba_pkg::kind_read, cba_pkg::md_indexed_offset16, 16'h8000, 8'h00, 0, 16'h9230, 1, 1, 16'h1230, 16'h0200, 16'h0002,
      8'hf8},
    '{cba_pkg::kind_read, cba_pkg::md_indexed_post_increment, 16'h0000, 8'h00, 0, 16'h1230, 1, 1, 16'h1231, 16'h0200,
      16'h0002, 8'h78},
    '{cba_pkg::kind_read, cba_pkg::md_indexed_offset8_post_increment, 16'h0080, 8'h00, 0, 16'h12b1, 1, 1, 16'h1232,
      16'h0200, 16'h0002, 8'hf9},
    '{cba_pkg::kind_write, cba_pkg::md_stack_offset8, 16'h0010, 8'hc3, 0, 16'h0210, 0, 1, 16'h1232, 16'h0200, 16'h0002,
      8'h00},
    '{cba_pkg::kind_write, cba_pkg::md_stack_offset16, 16'h1000, 8'h96, 0, 16'h1200, 0, 1, 16'h1232, 16'h0200, 16'h0002,
      8'h00},
    '{cba_pkg::kind_push, cba_pkg::md_direct, 16'h0000, 8'ha5, 0, 16'h0200, 0, 1, 16'h1232, 16'h01ff, 16'h0002, 8'h00},
    '{cba_pkg::kind_push, cba_pkg::md_direct, 16'h0000, 8'h3c, 0, 16'h01ff, 0, 1, 16'h1232, 16'h01fe, 16'h0002, 8'h00},
    '{cba_pkg::kind_pop, cba_pkg::md_direct, 16'h0000, 8'h00, 0, 16'h01ff, 1, 1, 16'h1232, 16'h01ff, 16'h0002, 8'h3c},
    '{cba_pkg::kind_free, cba_pkg::md_relative, 16'h00fe, 8'h00, 1, 16'h01ff, 1, 0, 16'h1232, 16'h01ff, 16'h0000, 8'h00},
    '{cba_pkg::kind_free, cba_pkg::md_relative, 16'h007f, 8'h00, 1, 16'h01ff, 1, 0, 16'h1232, 16'h01ff, 16'h007f, 8'h00}
  };

  cba_bus_cycle DUT (.i_clk_sys(clk), .i_arst_n(rst_n), .i_cyc_valid(valid), .i_cyc_kind(kind), .i_mode(mode),
    .i_offset(offset), .i_vec_lo(vec_lo), .i_wdata(wdata), .i_take_branch(br), .i_load_hx(ld_hx), .i_load_sp(ld_sp),
    .i_load_value(ld_val), .i_mem_rdata(mem_rd), .o_ready(ready), .o_bus_en(bus_en), .o_bus_rw(bus_rw), .o_addr(addr),
    .o_wdata(bus_wd), .o_cyc_kind(cyc_kind), .o_rdata(rdata), .o_rdata_valid(rd_valid), .o_pc(pc), .o_sp(sp),
    .o_hx(hx));
  cba_mem_model mem (.i_clk_sys(clk), .i_bus_en(bus_en), .i_bus_rw(bus_rw), .i_addr(addr), .i_wdata(bus_wd),
    .o_rdata(mem_rd));

  initial begin
    forever #12.5 clk = ~clk;
  end

  task automatic complete_run();
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Only the request cycle is held; the design takes it at the edge that ends it
  task automatic req(input cba_row_t r);
    @(posedge clk);
    valid <= 1'b1;
    kind <= r.k;
    mode <= r.m;
    offset <= r.ofs;
    wdata <= r.wd;
    br <= r.br;
    @(posedge clk);
    valid <= 1'b0;
    br <= 1'b0;
    #1;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    while (ready !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 20) begin
        num_errors++;
        complete_run();
      end
    end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    #1;
    `CHK(ready, 1'b0, "ready in reset")
    `CHK(sp, 16'h00ff, "sp reset")
    `CHK(bus_en, 1'b0, "bus idle in reset")
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ld_hx <= 1'b1;
    ld_sp <= 1'b1;
    ld_val <= 16'h1230;
    @(posedge clk);
    ld_hx <= 1'b0;
    ld_val <= 16'h0200;
    @(posedge clk);
    ld_sp <= 1'b0;
    #1;
    wait_ready();
    foreach (rows[i]) begin
      req(rows[i]);
      `CHK(addr, rows[i].addr, "address")
      `CHK(bus_rw, rows[i].rw, "direction")
      `CHK(bus_en, rows[i].en, "bus use")
      `CHK(cyc_kind, rows[i].k, "cycle kind")
      `CHK(hx, rows[i].hx, "index pair")
      `CHK(sp, rows[i].sp, "stack pointer")
      `CHK(pc, rows[i].pc, "program counter")
      if (!rows[i].rw) `CHK(bus_wd, rows[i].wd, "write byte")
      @(posedge clk);
      #1;
      `CHK(bus_en, 1'b0, "single cycle")
      if (rows[i].k == cba_pkg::kind_read || rows[i].k == cba_pkg::kind_pop) begin
        @(posedge clk);
        #1;
        `CHK(rd_valid, 1'b1, "read valid")
        `CHK(rdata, rows[i].rd, "read byte")
      end
    end
    @(posedge clk);
    vec_lo <= 8'hfe;
    req('{cba_pkg::kind_vector, cba_pkg::md_direct, 16'h0000, 8'h00, 0, 16'h0, 1, 1, 16'h0, 16'h0, 16'h0, 8'h0});
    `CHK(addr, 16'hfffe, "vector high byte first")
    `CHK(ready, 1'b0, "busy in vector")
    @(posedge clk);
    #1;
    `CHK(addr, 16'hffff, "vector low byte")
    wait_ready();
    `CHK(pc, 16'h5b5a, "vector loaded")
    // Two fetches back to back must step the counter each cycle
    @(posedge clk);
    valid <= 1'b1;
    kind <= cba_pkg::kind_fetch;
    @(posedge clk);
    #1;
    `CHK(addr, 16'h5b5a, "first fetch")
    @(posedge clk);
    valid <= 1'b0;
    #1;
    `CHK(addr, 16'h5b5b, "next fetch")
    `CHK(pc, 16'h5b5c, "pc after fetches")
    // Index load must win over a post-increment taken in the same clock
    @(posedge clk);
    valid <= 1'b1;
    kind <= cba_pkg::kind_read;
    mode <= cba_pkg::md_indexed_post_increment;
    ld_hx <= 1'b1;
    ld_val <= 16'h4000;
    @(posedge clk);
    valid <= 1'b0;
    ld_hx <= 1'b0;
    #1;
    `CHK(addr, 16'h1232, "post-increment address")
    `CHK(hx, 16'h4000, "load wins over step")
    // Reset in mid-run clears pc and hx, sets sp to 00ff, and fetching restarts at zero
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    `CHK(pc, 16'h0000, "pc after mid-run reset")
    `CHK(sp, 16'h00ff, "sp after mid-run reset")
    `CHK(hx, 16'h0000, "hx after mid-run reset")
    `CHK(bus_en, 1'b0, "bus idle after mid-run reset")
    `CHK(rd_valid, 1'b0, "no read byte in reset")
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(ready, 1'b1, "ready after reset")
    req(rows[0]);
    `CHK(addr, 16'h0000, "fetch after reset")
    `CHK(pc, 16'h0001, "pc after reset fetch")
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    complete_run();
  end
endmodule
